// ==== common/asmi_pkg.sv ====
// Package with constants and carrier types for the converter serial interface
`default_nettype none
package asmi_pkg;
    localparam int RESULT_BITS = 16;
    localparam int CFG_BITS = 2;
    localparam int CLOCK_MHZ = 125;
    localparam int CONVERSION_TIME_NS = 3200;
    localparam int CONVERSION_CYCLES = (CONVERSION_TIME_NS * CLOCK_MHZ + 999) / 1000;
    localparam int FIFO_DEPTH = 4;
    localparam logic [1:0] CFG_RESET = 2'h2;
    localparam int CFG_SGL_POS = 1;
    localparam int CFG_POL_POS = 0;

    typedef enum logic [1:0] {
        ASMI_SAMPLE = 2'b00,
        ASMI_CONVERT = 2'b01,
        ASMI_SLEEP = 2'b10
    } asmi_state_t;

    // Multiplexer routing: which input feeds each side of the converter
    typedef struct packed {
        logic pos_is_one;
        logic neg_is_ground;
        logic neg_is_one;
    } asmi_mux_t;

    // Conversion request with its routing and sampled inputs
    typedef struct packed {
        asmi_mux_t mux;
        logic [RESULT_BITS-1:0] pos_level;
        logic [RESULT_BITS-1:0] neg_level;
    } asmi_sample_t;
endpackage
`default_nettype wire

// ==== src/asmi_fifo.sv ====
// Small flip-flop FIFO with valid and ready on both sides
`default_nettype none
module asmi_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign o_in_ready = count != (AW+1)'(DEPTH);
    assign o_out_valid = count != '0;
    assign o_out_data = mem[rd_ptr];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always_ff @(posedge i_clock) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// ==== src/asmi_core.sv ====
// Control and serial interface of a two-channel converter
// What this block does
// - A rising convert strobe starts a conversion cycle.
// - Conversion ends after conversion time; strobe still high then means sleep.
// - After strobe falls, two config bits are sampled on rising shift clock.
// - Further serial input bits are ignored until the next conversion.
// - Output bits change on falling shift edge; inputs sampled on rising edge.
// - Config input and result output share the same shift pulses, full duplex.
// - Extra shift pulses after the result give zeros on the output.
// - Captured config applies to the next conversion, not the current result.
// - Decode: single-ended picks channel against ground; differential picks pair order.
// - Single-ended mode converts the chosen channel relative to ground.
// - Equal inputs give zero code; difference of full span gives full scale.
// - Output driven while strobe low, disabled while strobe high.
// - Falling strobe, or conversion end with strobe already low, enters sample mode until the next rising edge.
`default_nettype none
module asmi_core #(
    parameter int RESULT_BITS = asmi_pkg::RESULT_BITS,
    parameter int CONVERSION_CYCLES = asmi_pkg::CONVERSION_CYCLES,
    parameter int FIFO_DEPTH = asmi_pkg::FIFO_DEPTH
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_convert_strobe,
    input wire logic i_shift_clock,
    input wire logic i_config_serial_in,
    input wire logic [RESULT_BITS-1:0] i_analog_channel_zero,
    input wire logic [RESULT_BITS-1:0] i_analog_channel_one,
    output logic o_result_serial_out,
    output logic o_result_serial_oe,
    output logic o_sleep,
    output logic o_sampling,
    output logic [1:0] o_mux_config
);
    localparam int CW = $clog2(CONVERSION_CYCLES + 1);
    localparam int BW = $clog2(RESULT_BITS + 1);

    logic [2:0] convert_strobe_sync;
    logic [2:0] sck_sync;
    logic [1:0] cfg_in_sync;
    logic convert_strobe_rise;
    logic convert_strobe_fall;
    logic sck_rise;
    logic sck_fall;
    logic convert_strobe_level;
    asmi_pkg::asmi_state_t state;
    logic [CW-1:0] convert_strobe_count;
    logic [1:0] cfg_shift;
    logic [1:0] cfg_count;
    logic [1:0] mux_config;
    logic [1:0] active_config;
    logic [RESULT_BITS-1:0] out_shift;
    logic [BW-1:0] out_count;
    logic out_loaded;
    asmi_pkg::asmi_sample_t sample;
    logic [RESULT_BITS-1:0] next_code;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [RESULT_BITS-1:0] fifo_out_data;
    logic fifo_pop;

    // Decode of a two-bit config into multiplexer routing
    function automatic asmi_pkg::asmi_mux_t decode_mux(input logic [1:0] cfg);
        asmi_pkg::asmi_mux_t m;
        m.pos_is_one = cfg[asmi_pkg::CFG_POL_POS];
        m.neg_is_ground = cfg[asmi_pkg::CFG_SGL_POS];
        m.neg_is_one = !cfg[asmi_pkg::CFG_SGL_POS] && !cfg[asmi_pkg::CFG_POL_POS];
        return m;
    endfunction

    // Two-stage synchronisers, third stage for edge finding
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            convert_strobe_sync <= 3'h0;
            sck_sync <= 3'h0;
            cfg_in_sync <= 2'h0;
        end else begin
            convert_strobe_sync <= {convert_strobe_sync[1:0], i_convert_strobe};
            sck_sync <= {sck_sync[1:0], i_shift_clock};
            cfg_in_sync <= {cfg_in_sync[0], i_config_serial_in};
        end
    end

    assign convert_strobe_level = convert_strobe_sync[1];
    assign convert_strobe_rise = convert_strobe_sync[1] && !convert_strobe_sync[2];
    assign convert_strobe_fall = !convert_strobe_sync[1] && convert_strobe_sync[2];
    assign sck_rise = sck_sync[1] && !sck_sync[2];
    assign sck_fall = !sck_sync[1] && sck_sync[2];

    // Conversion state and timer
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            state <= asmi_pkg::ASMI_SAMPLE;
            convert_strobe_count <= '0;
        end else begin
            case (state)
                asmi_pkg::ASMI_SAMPLE: begin
                    if (convert_strobe_rise) begin
                        state <= asmi_pkg::ASMI_CONVERT;
                        convert_strobe_count <= CW'(CONVERSION_CYCLES);
                    end
                end
                asmi_pkg::ASMI_CONVERT: begin
                    if (convert_strobe_count > CW'(1)) begin
                        convert_strobe_count <= convert_strobe_count - 1'b1;
                    end else if (convert_strobe_level) begin
                        state <= asmi_pkg::ASMI_SLEEP;
                    end else begin
                        state <= asmi_pkg::ASMI_SAMPLE;
                    end
                end
                asmi_pkg::ASMI_SLEEP: begin
                    if (!convert_strobe_level) begin
                        state <= asmi_pkg::ASMI_SAMPLE;
                    end
                end
                default: begin
                    state <= asmi_pkg::ASMI_SAMPLE;
                end
            endcase
        end
    end

    // Inputs held for conversion are the latest sampled levels at the start
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            sample <= '0;
            active_config <= asmi_pkg::CFG_RESET;
        end else if (state == asmi_pkg::ASMI_SAMPLE && convert_strobe_rise) begin
            sample.mux <= decode_mux(mux_config);
            sample.pos_level <= mux_config[asmi_pkg::CFG_POL_POS] ? i_analog_channel_one : i_analog_channel_zero;
            sample.neg_level <= mux_config[asmi_pkg::CFG_SGL_POS] ? '0 :
                (mux_config[asmi_pkg::CFG_POL_POS] ? i_analog_channel_zero : i_analog_channel_one);
            active_config <= mux_config;
        end
    end

    // Unipolar code: difference, clamped at zero
    always_comb begin
        if (sample.pos_level > sample.neg_level) begin
            next_code = sample.pos_level - sample.neg_level;
        end else begin
            next_code = '0;
        end
    end

    // Result enters the buffer when the conversion ends
    asmi_fifo #(
        .WIDTH(RESULT_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_in_valid(state == asmi_pkg::ASMI_CONVERT && convert_strobe_count <= CW'(1)),
        .o_in_ready(fifo_in_ready),
        .i_in_data(next_code),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(fifo_pop),
        .o_out_data(fifo_out_data)
    );

    assign fifo_pop = convert_strobe_fall && fifo_out_valid;

    // Config word capture on rising shift edges after the strobe falls
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            cfg_shift <= 2'h0;
            cfg_count <= 2'h0;
            mux_config <= asmi_pkg::CFG_RESET;
        end else if (convert_strobe_level) begin
            cfg_count <= 2'h0;
        end else if (sck_rise && cfg_count < 2'h2) begin
            cfg_shift <= {cfg_shift[0], cfg_in_sync[1]};
            cfg_count <= cfg_count + 1'b1;
            if (cfg_count == 2'h1) begin
                mux_config <= {cfg_shift[0], cfg_in_sync[1]};
            end
        end
    end

    // Result shift-out: first bit at strobe fall, next bits on falling shift edges
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            out_shift <= '0;
            out_count <= '0;
            out_loaded <= 1'b0;
        end else if (convert_strobe_level) begin
            out_loaded <= 1'b0;
            out_count <= '0;
        end else if (convert_strobe_fall) begin
            out_shift <= fifo_out_valid ? fifo_out_data : '0;
            out_count <= BW'(RESULT_BITS);
            out_loaded <= 1'b1;
        end else if (sck_fall && out_loaded) begin
            out_shift <= {out_shift[RESULT_BITS-2:0], 1'b0};
            if (out_count != '0) begin
                out_count <= out_count - 1'b1;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_result_serial_out <= 1'b0;
            o_result_serial_oe <= 1'b0;
            o_sleep <= 1'b0;
            o_sampling <= 1'b1;
            o_mux_config <= asmi_pkg::CFG_RESET;
        end else begin
            o_result_serial_out <= out_shift[RESULT_BITS-1] && out_count != '0;
            o_result_serial_oe <= !convert_strobe_level;
            o_sleep <= state == asmi_pkg::ASMI_SLEEP;
            o_sampling <= state == asmi_pkg::ASMI_SAMPLE;
            o_mux_config <= active_config;
        end
    end
endmodule
`default_nettype wire

// ==== test/asmi_core_checker.sv ====
// Port assertions for the converter serial interface
`default_nettype none
module asmi_core_checker #(parameter int RESULT_BITS = 16, parameter int CONVERSION_CYCLES = 400,
    parameter int FIFO_DEPTH = 4) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_convert_strobe,
    input wire logic i_shift_clock,
    input wire logic i_config_serial_in,
    input wire logic [RESULT_BITS-1:0] i_analog_channel_zero,
    input wire logic [RESULT_BITS-1:0] i_analog_channel_one,
    input wire logic o_result_serial_out,
    input wire logic o_result_serial_oe,
    input wire logic o_sleep,
    input wire logic o_sampling,
    input wire logic [1:0] o_mux_config
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    logic [15:0] hi_cnt;
    logic [7:0] falls;
    logic [3:0] gap;
    logic sck_d;
    // Cycles of strobe high, shift falls in frame, cycles since a shift edge
    always_ff @(posedge i_clock) begin
        hi_cnt <= (i_sys_rst || !i_convert_strobe) ? 16'h0000 : hi_cnt + {15'h0000, hi_cnt != 16'hFFFF};
    end
    always_ff @(posedge i_clock) begin
        sck_d <= i_shift_clock;
        gap <= (i_sys_rst || sck_d != i_shift_clock) ? 4'h0 : gap + {3'h0, gap != 4'hF};
        falls <= (i_sys_rst || i_convert_strobe) ? 8'h00 : falls + {7'h00, sck_d && !i_shift_clock};
    end
    property p_start; $rose(i_convert_strobe) |-> ##[1:6] !o_sampling; endproperty
    a_start: assert property (p_start) else $error("sampling kept after strobe rise");
    property p_early; i_convert_strobe && hi_cnt < CONVERSION_CYCLES |-> !o_sleep; endproperty
    a_early: assert property (p_early) else $error("sleep before conversion end");
    property p_sleep; hi_cnt == CONVERSION_CYCLES + 8 |-> o_sleep; endproperty
    a_sleep: assert property (p_sleep) else $error("no sleep with strobe high");
    property p_wake; !i_convert_strobe [*6] |-> !o_sleep; endproperty
    a_wake: assert property (p_wake) else $error("sleep with strobe low");
    property p_oe_off; i_convert_strobe [*5] |-> !o_result_serial_oe; endproperty
    a_oe_off: assert property (p_oe_off) else $error("output on with strobe high");
    property p_oe_on; $fell(i_convert_strobe) |-> ##[1:6] o_result_serial_oe; endproperty
    a_oe_on: assert property (p_oe_on) else $error("output off after strobe fall");
    property p_samp; !i_convert_strobe [*5] |-> o_sampling; endproperty
    a_samp: assert property (p_samp) else $error("not sampling with strobe low");
    property p_cfg; !i_convert_strobe [*5] |=> $stable(o_mux_config); endproperty
    a_cfg: assert property (p_cfg) else $error("routing changed during readout");
    property p_tail; !i_convert_strobe && falls >= RESULT_BITS && gap >= 4'h6 |-> !o_result_serial_out; endproperty
    a_tail: assert property (p_tail) else $error("nonzero bit after result");
endmodule
bind asmi_core asmi_core_checker #(.RESULT_BITS(RESULT_BITS), .CONVERSION_CYCLES(CONVERSION_CYCLES),
    .FIFO_DEPTH(FIFO_DEPTH)) u_chk (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_convert_strobe(i_convert_strobe), .i_shift_clock(i_shift_clock), .i_config_serial_in(i_config_serial_in),
    .i_analog_channel_zero(i_analog_channel_zero), .i_analog_channel_one(i_analog_channel_one),
    .o_result_serial_out(o_result_serial_out), .o_result_serial_oe(o_result_serial_oe), .o_sleep(o_sleep),
    .o_sampling(o_sampling), .o_mux_config(o_mux_config));
`default_nettype wire

// ==== test/asmi_host_model.sv ====
// Host model: strobe, shift clock and config bits, collects result bits
`default_nettype none
module asmi_host_model (
    input wire logic i_clock,
    input wire logic i_result_bit,
    output logic o_strobe,
    output logic o_sck,
    output logic o_cfg_bit
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_strobe = 1'b0;
        o_sck = 1'b0;
        o_cfg_bit = 1'b0;
    end
    task automatic set_strobe(input logic lvl);
        @(negedge i_clock);
        o_strobe = lvl;
    endtask
    // Shift clock runs only inside a frame, 64 ns period, edges on falling system clock
    task automatic frame(input logic [1:0] cfg, input int pulses, output logic [17:0] got);
        got = '0;
        for (int i = 0; i < pulses; i++) begin
            o_cfg_bit = (i < 2) ? cfg[1-i] : ~o_cfg_bit;
            #32 o_sck = 1'b1;
            got = {got[16:0], i_result_bit};
            #32 o_sck = 1'b0;
        end
        o_cfg_bit = ~o_cfg_bit;
    endtask
endmodule
`default_nettype wire

// ==== test/asmi_core_tb.sv ====
// Testbench for the converter serial interface
`default_nettype none
module asmi_core_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int SHORT_CYCLES = 20;
    typedef struct packed {logic [1:0] cfg; logic [15:0] c0; logic [15:0] c1; logic [15:0] res;} asmi_row_t;
    logic i_clock, i_sys_rst, strobe, sck, cfg_bit, res_bit, oe, sleep, sampling;
    logic [15:0] level_zero, level_one;
    logic [1:0] mux, prev;
    logic [17:0] got;
    int err_count = 0;
    int n_tests = 0;
    int cycles = 0;
    asmi_row_t rows [6] = '{'{2'h3, 16'h1234, 16'h0100, 16'h1234}, '{2'h0, 16'h0200, 16'hABCD, 16'hABCD},
        '{2'h1, 16'h9000, 16'h1000, 16'h8000}, '{2'h0, 16'h5555, 16'hFFFF, 16'hAAAA},
        '{2'h2, 16'h4321, 16'h4321, 16'h0000}, '{2'h2, 16'h7777, 16'h0001, 16'h7777}};
    asmi_core #(.CONVERSION_CYCLES(SHORT_CYCLES)) uut (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
        .i_convert_strobe(strobe), .i_shift_clock(sck), .i_config_serial_in(cfg_bit),
        .i_analog_channel_zero(level_zero), .i_analog_channel_one(level_one), .o_result_serial_out(res_bit),
        .o_result_serial_oe(oe), .o_sleep(sleep), .o_sampling(sampling), .o_mux_config(mux));
    asmi_host_model host (.i_clock(i_clock), .i_result_bit(res_bit), .o_strobe(strobe), .o_sck(sck),
        .o_cfg_bit(cfg_bit));
    initial begin
        i_clock = 1'b0;
        forever #4 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            wrap_up();
        end
    end
    task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // One conversion, then a full-duplex frame with two extra pulses
    task automatic convert_strobe_read(input asmi_row_t r);
        @(negedge i_clock);
        level_zero = r.c0;
        level_one = r.c1;
        host.set_strobe(1'h1);
        repeat (8) @(negedge i_clock);
        check("sampling", sampling, 18'h0);
        check("oe", oe, 18'h0);
        check("mux", mux, prev);
        repeat (SHORT_CYCLES + 10) @(negedge i_clock);
        check("sleep", sleep, 18'h1);
        host.set_strobe(1'h0);
        repeat (8) @(negedge i_clock);
        check("oe", oe, 18'h1);
        check("sleep", sleep, 18'h0);
        check("sampling", sampling, 18'h1);
        host.frame(r.cfg, 18, got);
        check("result", got, {r.res, 2'h0});
        prev = r.cfg;
        repeat (8) @(negedge i_clock);
        $display("conversion test done");
    endtask
    initial begin
        i_sys_rst = 1'h1;
        level_zero = 16'h0000;
        level_one = 16'h0000;
        prev = 2'h2;
        repeat (5) @(negedge i_clock);
        i_sys_rst = 1'h0;
        repeat (4) @(negedge i_clock);
        check("sampling", sampling, 18'h1);
        check("mux", mux, 18'h2);
        $display("reset test done");
        foreach (rows[k]) begin
            convert_strobe_read(rows[k]);
        end
        // Reset after a full config word, in mid-frame, brings back default routing
        host.set_strobe(1'h1);
        repeat (SHORT_CYCLES + 10) @(negedge i_clock);
        host.set_strobe(1'h0);
        repeat (8) @(negedge i_clock);
        host.frame(2'h1, 3, got);
        @(negedge i_clock);
        i_sys_rst = 1'h1;
        repeat (2) @(negedge i_clock);
        i_sys_rst = 1'h0;
        prev = 2'h2;
        repeat (4) @(negedge i_clock);
        check("oe", oe, 18'h1);
        check("sleep", sleep, 18'h0);
        $display("mid-frame reset test done");
        convert_strobe_read({2'h0, 16'h0042, 16'hF000, 16'h0042});
        wrap_up();
    end
endmodule
`default_nettype wire
